// ===== logic/guard_timer.v
/*
  busy timer for guard operations: loads a cycle count on start and pulses
  done when it runs out.
  assumes start is only given while idle.
*/
`timescale 1ns/1ps
module guard_timer (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // control
  input  wire        start,
  input  wire [31:0] load,
  // state
  output reg         busy,
  output reg         done
);

  reg [31:0] cnt_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 32'h00000000;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_q <= (load == 32'h00000000) ? 32'h00000001 : load;
        busy  <= 1'b1;
      end else if (busy) begin
        if (cnt_q == 32'h00000001) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        cnt_q <= cnt_q - 32'h00000001;
      end
    end
  end

endmodule

// ===== logic/password_vault.v
/*
  hidden 64-bit password store with match output.
  assumes the caller blocks programming once password mode is fixed.
*/
`timescale 1ns/1ps
`include "sector_guard_consts.vh"
module password_vault (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // program and compare
  input  wire        prog,
  input  wire [63:0] data,
  output wire        match
);

  reg [63:0] pwd_q;

  // one-time cells: only zeros can be written, a later one is lost
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwd_q <= `PWD_RESET;
    end else if (prog) begin
      pwd_q <= pwd_q & data;
    end
  end

  assign match = (pwd_q == data);

endmodule

// ===== logic/sector_guard.v
/*
  sector write protection: block range, per-sector guard bits, guard lock
  and its mode, reached over apb.
  assumes presetn is power-on; hw_reset_n and wp_n are asynchronous pins.
*/
`timescale 1ns/1ps
`include "sector_guard_consts.vh"
module sector_guard #(
  parameter        SAW          = 6,
  parameter [31:0] PAGE_CYC     = `PAGE_PROG_US * `CLK_MHZ,
  parameter [31:0] ERASE_CYC    = `SECT_ERASE_US * `CLK_MHZ,
  parameter [31:0] UNLOCK_CYC   = `UNLOCK_GAP_US * `CLK_MHZ
) (
  // apb slave
  input  wire               pclk,
  input  wire               presetn,
  input  wire               psel,
  input  wire               penable,
  input  wire               pwrite,
  input  wire [7:0]         paddr,
  input  wire [31:0]        pwdata,
  output reg  [31:0]        prdata,
  output reg                pready,
  output reg                pslverr,
  // pins
  input  wire               wp_n,
  input  wire               hw_reset_n,
  // protection state
  output reg                write_in_progress_flag,
  output reg                guard_lock_bit,
  output reg  [(1<<SAW)-1:0] sector_prot
);

  localparam NS = 1 << SAW;
  localparam [SAW:0] NS_W = NS;
  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [1:0] wp_s_q;
  reg [1:0] hr_s_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_s_q <= 2'b11;
      hr_s_q <= 2'b11;
    end else begin
      wp_s_q <= {wp_s_q[0], wp_n};
      hr_s_q <= {hr_s_q[0], hw_reset_n};
    end
  end
  wire wp_low   = ~wp_s_q[1];
  wire hw_reset = ~hr_s_q[1];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [NS-1:0]  nv_q;
  reg [NS-1:0]  v_q;
  reg [1:0]     mode_q;
  reg [2:0]     bp_q;
  reg           tbprot_q;
  reg           status_write_disable_bit_q;
  reg           perr_q;
  reg           chk_q;
  reg           rd_nv_q;
  reg           rd_v_q;
  reg [63:0]    stage_q;
  reg           state_q;
  reg [3:0]     pend_op_q;
  reg [SAW-1:0] pend_sec_q;
  reg [1:0]     pend_mode_q;

  wire password_mode = (mode_q == `MODE_PASSWORD);

  // ----------------------------------------------------------------
  // protection functions
  // ----------------------------------------------------------------
  function block_hit;
    input [SAW-1:0] idx;
    input [2:0]     bp;
    input           tb;
    reg   [SAW:0]   cnt;
    begin
      if (bp == 3'd0)
        cnt = {(SAW+1){1'b0}};
      else if (bp == 3'd7)
        cnt = NS_W;
      else
        cnt = NS_W >> (3'd7 - bp);
      block_hit = tb ? ({1'b0, idx} < cnt) : ({1'b0, idx} >= NS_W - cnt);
    end
  endfunction

  function combined;
    input [SAW-1:0] idx;
    begin
      combined = block_hit(idx, bp_q, tbprot_q) | ~nv_q[idx] | ~v_q[idx];
    end
  endfunction

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire access  = psel & penable & pready;
  wire wr      = access & pwrite;
  wire known   = (paddr == `OFS_CMD) | (paddr == `OFS_STATUS) | (paddr == `OFS_SR) |
                 (paddr == `OFS_MODE) | (paddr == `OFS_PWD_LO) | (paddr == `OFS_PWD_HI);
  wire idle    = (state_q == ST_IDLE);
  wire cmd_wr  = wr & (paddr == `OFS_CMD) & idle;
  wire [3:0]     op  = pwdata[`CMD_OP_LSB +: 4];
  wire [SAW-1:0] sec = pwdata[`CMD_SEC_LSB +: SAW];
  wire sr_wr   = wr & (paddr == `OFS_SR) & idle;
  wire mode_wr = wr & (paddr == `OFS_MODE) & idle;
  wire [1:0] mode_new = mode_q & pwdata[`MODE_LSB +: 2];

  wire [31:0] status_word = {24'h000000, rd_v_q, rd_nv_q, chk_q, mode_q,
                             guard_lock_bit, perr_q, write_in_progress_flag};
  wire [31:0] sr_word     = {24'h000000, status_write_disable_bit_q, 1'b0, tbprot_q, bp_q, 2'b00};

  reg [31:0] rdata;
  always @* begin
    case (paddr)
      `OFS_STATUS: rdata = status_word;
      `OFS_SR:     rdata = sr_word;
      `OFS_MODE:   rdata = {29'h00000000, mode_q, 1'b0};
      `OFS_PWD_LO: rdata = stage_q[31:0];
      `OFS_PWD_HI: rdata = stage_q[63:32];
      default:     rdata = 32'h00000000;
    endcase
  end

  // one wait state so read data leaves a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~known;
      if (psel & penable & ~pready & ~pwrite)
        prdata <= rdata;
    end
  end

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  wire pwd_match;
  wire tmr_busy;
  wire tmr_done;
  reg  tmr_start;
  reg  [31:0] tmr_load;

  // programming refused once password mode is fixed
  password_vault u_vault (
    .clk   (pclk),
    .rst_n (presetn),
    .prog  (cmd_wr & (op == `OP_PWD_PROG) & ~password_mode),
    .data  (stage_q),
    .match (pwd_match)
  );

  guard_timer u_timer (
    .clk   (pclk),
    .rst_n (presetn),
    .start (tmr_start),
    .load  (tmr_load),
    .busy  (tmr_busy),
    .done  (tmr_done)
  );

  always @* begin
    tmr_start = 1'b0;
    tmr_load  = PAGE_CYC;
    if (mode_wr && mode_q == `MODE_DEFAULT && mode_new != `MODE_ILLEGAL) begin
      tmr_start = 1'b1;
    end else if (cmd_wr) begin
      case (op)
        `OP_NV_PROG: begin
          tmr_start = guard_lock_bit;
        end
        `OP_NV_ERASE: begin
          tmr_start = guard_lock_bit;
          tmr_load  = ERASE_CYC;
        end
        `OP_PWD_UNLOCK: begin
          tmr_start = password_mode & ~pwd_match;
          tmr_load  = UNLOCK_CYC;
        end
        default: begin
          tmr_start = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // guard logic
  // ----------------------------------------------------------------
  integer i;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_q                   <= {NS{1'b1}};
      v_q                    <= {NS{1'b1}};
      mode_q                 <= `MODE_DEFAULT;
      bp_q                   <= 3'b000;
      tbprot_q               <= 1'b0;
      status_write_disable_bit_q                 <= 1'b0;
      perr_q                 <= 1'b0;
      chk_q                  <= 1'b0;
      rd_nv_q                <= 1'b1;
      rd_v_q                 <= 1'b1;
      stage_q                <= 64'h0000000000000000;
      state_q                <= ST_IDLE;
      pend_op_q              <= 4'h0;
      pend_sec_q             <= {SAW{1'b0}};
      pend_mode_q            <= `MODE_DEFAULT;
      write_in_progress_flag <= 1'b0;
      guard_lock_bit         <= 1'b1;
      sector_prot            <= {NS{1'b0}};
    end else if (hw_reset) begin
      // volatile bits open on hardware reset
      v_q                    <= {NS{1'b1}};
      guard_lock_bit         <= ~password_mode;
      state_q                <= ST_IDLE;
      write_in_progress_flag <= 1'b0;
      perr_q                 <= 1'b0;
    end else begin
      for (i = 0; i < NS; i = i + 1)
        sector_prot[i] <= combined(i[SAW-1:0]);
      if (wr && paddr == `OFS_PWD_LO)
        stage_q[31:0] <= pwdata;
      if (wr && paddr == `OFS_PWD_HI)
        stage_q[63:32] <= pwdata;
      // frozen by pin and write-disable bit
      if (sr_wr && !(wp_low && status_write_disable_bit_q)) begin
        bp_q     <= pwdata[`SR_BP_LSB +: 3];
        tbprot_q <= pwdata[`SR_TBPROT];
        status_write_disable_bit_q   <= pwdata[`SR_STATUS_WRITE_DISABLE_BIT];
      end
      if (cmd_wr && op == `OP_ERR_CLEAR)
        perr_q <= 1'b0;
      if (mode_wr) begin
        // both bits zero is an error
        if (mode_q != `MODE_DEFAULT || mode_new == `MODE_ILLEGAL) begin
          perr_q <= 1'b1;
        end else begin
          pend_op_q              <= 4'h0;
          pend_mode_q            <= mode_new;
          state_q                <= ST_BUSY;
          write_in_progress_flag <= 1'b1;
        end
      end
      if (cmd_wr) begin
        case (op)
          `OP_NV_PROG, `OP_NV_ERASE: begin
            if (!guard_lock_bit) begin
              perr_q <= 1'b1;
            end else begin
              pend_op_q              <= op;
              pend_sec_q             <= sec;
              state_q                <= ST_BUSY;
              write_in_progress_flag <= 1'b1;
            end
          end
          `OP_V_CLEAR: v_q[sec] <= 1'b0;
          `OP_V_SET:   v_q[sec] <= 1'b1;
          `OP_LOCK_CLEAR: guard_lock_bit <= 1'b0;
          `OP_PWD_UNLOCK: begin
            // persistent mode has no way to set
            if (password_mode) begin
              if (pwd_match) begin
                guard_lock_bit <= 1'b1;
              end else begin
                // mismatch: error, busy for the gap
                perr_q                 <= 1'b1;
                pend_op_q              <= op;
                state_q                <= ST_BUSY;
                write_in_progress_flag <= 1'b1;
              end
            end
          end
          `OP_SOFT_RESET: v_q <= {NS{1'b1}};
          // check before array program or erase
          `OP_ARRAY_CHECK: begin
            chk_q <= combined(sec);
            if (combined(sec))
              perr_q <= 1'b1;
          end
          `OP_READ_GUARD: begin
            rd_nv_q <= nv_q[sec];
            rd_v_q  <= v_q[sec];
          end
          default: begin
            chk_q <= chk_q;
          end
        endcase
      end
      if (state_q == ST_BUSY && tmr_done) begin
        state_q                <= ST_IDLE;
        write_in_progress_flag <= 1'b0;
        case (pend_op_q)
          // one bit to zero, all to one
          `OP_NV_PROG:    nv_q[pend_sec_q] <= 1'b0;
          `OP_NV_ERASE:   nv_q <= {NS{1'b1}};
          `OP_PWD_UNLOCK: nv_q <= nv_q;
          default:        mode_q <= pend_mode_q;
        endcase
      end
    end
  end

endmodule

// ===== logic/sector_guard_consts.vh
/*
  constants of the sector write protection block: apb offsets, field
  positions, reset values, command codes and operation times.
  assumes a 100 MHz pclk and 32-bit apb data.
*/
// What this block does
// - wp pin low with write-disable bit set freezes status and config bits.
// - sector protected when block range or per-sector scheme protects it.
// - each sector has nonvolatile and volatile guard bit; either 0 protects.
// - lock bit 0 makes nonvolatile bit program or erase fail unchanged.
// - persistent mode sets lock bit at power-on and hardware reset.
// - persistent mode: no command sets lock bit again once cleared.
// - password mode clears lock bit at hardware reset; power-on resets mode to 11 and sets lock bit.
// - password mode sets lock bit only on 64-bit password match.
// - lock-clear command clears lock bit in either mode.
// - mode field 11 default persistent, 10 persistent, 01 password, 00 fails.
// - unconfigured device starts persistent with all sectors unprotected.
// - once a mode bit is programmed, mode register changes are rejected.
// - mode register program takes a page-program time with busy shown.
// - nonvolatile bits program to 0 singly, erase to 1 together.
// - guard program takes page time, erase sector time, busy shown.
// - read command returns addressed sector's nonvolatile guard bit.
// - volatile write clears bit to protect or sets it to unprotect.
// - volatile bits accept unlimited set and clear, no lock.
// - volatile bits unprotected after power cycle, software or hardware reset.
// - software reset leaves lock bit unchanged.
// - unlock at most every 100 us; mismatch sets error, busy, lock 0.
`ifndef SECTOR_GUARD_CONSTS_VH
`define SECTOR_GUARD_CONSTS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_CMD        8'h00
`define OFS_STATUS     8'h04
`define OFS_SR         8'h08
`define OFS_MODE       8'h0c
`define OFS_PWD_LO     8'h10
`define OFS_PWD_HI     8'h14

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define CMD_OP_LSB     0
`define CMD_SEC_LSB    16
`define ST_WIP         0
`define ST_PERR        1
`define ST_LOCK        2
`define ST_MODE_LSB    3
`define ST_CHK_PROT    5
`define ST_RD_NV       6
`define ST_RD_V        7
`define SR_BP_LSB      2
`define SR_TBPROT      5
`define SR_STATUS_WRITE_DISABLE_BIT        7
`define MODE_LSB       1

// ----------------------------------------------------------------
// reset values and mode codes
// ----------------------------------------------------------------
`define MODE_DEFAULT   2'b11
`define MODE_PERSIST   2'b10
`define MODE_PASSWORD  2'b01
`define MODE_ILLEGAL   2'b00
`define PWD_RESET      64'hffffffffffffffff

// ----------------------------------------------------------------
// commands
// ----------------------------------------------------------------
`define OP_NV_PROG     4'h1
`define OP_NV_ERASE    4'h2
`define OP_V_CLEAR     4'h3
`define OP_V_SET       4'h4
`define OP_LOCK_CLEAR  4'h5
`define OP_PWD_UNLOCK  4'h6
`define OP_PWD_PROG    4'h8
`define OP_SOFT_RESET  4'h9
`define OP_ARRAY_CHECK 4'ha
`define OP_ERR_CLEAR   4'hb
`define OP_READ_GUARD  4'hc

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_MHZ        100
`define PAGE_PROG_US   250
`define SECT_ERASE_US  1000
`define UNLOCK_GAP_US  100

`endif

// ===== tb/apb_host.sv
/*
  apb master standing in for the host controller.
  assumes a free-running pclk; one transfer at a time.
*/
`timescale 1ns/1ps
module apb_host (
  // clock
  input  wire        pclk,
  // request
  output reg         psel,
  output reg         penable,
  output reg         pwrite,
  output reg  [7:0]  paddr,
  output reg  [31:0] pwdata,
  // answer
  input  wire [31:0] prdata,
  input  wire        pready,
  input  wire        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end
  // request held until pready seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // stale data must not look valid
    pwdata  <= ~d;
  endtask
endmodule

// ===== tb/sector_guard_asserts.sv
/*
  port checker of sector_guard.
  assumes one pclk domain and sim-sized busy counts.
*/
`timescale 1ns/1ps
`include "sector_guard_consts.vh"
module sector_guard_asserts #(
  parameter        SAW        = 6,
  parameter [31:0] PAGE_CYC   = 16,
  parameter [31:0] ERASE_CYC  = 20,
  parameter [31:0] UNLOCK_CYC = 12
) (
  // apb
  input wire                  pclk,
  input wire                  presetn,
  input wire                  psel,
  input wire                  penable,
  input wire                  pwrite,
  input wire [7:0]            paddr,
  input wire [31:0]           pwdata,
  input wire                  pready,
  input wire                  pslverr,
  // pins and state
  input wire                  hw_reset_n,
  input wire                  write_in_progress_flag,
  input wire                  guard_lock_bit,
  input wire [(1<<SAW)-1:0]   sector_prot
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  localparam [31:0] BUSY_MAX = PAGE_CYC + ERASE_CYC + UNLOCK_CYC;
  wire           cmd_wr = psel && penable && pready && pwrite && (paddr == `OFS_CMD);
  wire [3:0]     op     = pwdata[3:0];
  reg  [31:0]    busy_cnt_q;
  reg  [2:0]     cause_q;
  reg  [SAW-1:0] sec_q;
  // cause window covers the two-stage pin sync lag
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt_q <= 32'h0;
      cause_q    <= 3'h0;
      sec_q      <= {SAW{1'b0}};
    end else begin
      busy_cnt_q <= write_in_progress_flag ? busy_cnt_q + 32'h1 : 32'h0;
      if (!hw_reset_n || (cmd_wr && op == `OP_PWD_UNLOCK))
        cause_q <= 3'h4;
      else if (cause_q != 3'h0)
        cause_q <= cause_q - 3'h1;
      if (cmd_wr)
        sec_q <= pwdata[16 +: SAW];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_unmapped_err: assert property (psel && penable && pready && paddr > 8'h14 |-> pslverr)
    else $error("unmapped access without pslverr");
  a_mapped_ok: assert property (pready && paddr <= 8'h14 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access flagged");
  a_lock_cause: assert property ($rose(guard_lock_bit) |-> cause_q != 3'h0)
    else $error("lock bit set without reset or unlock");
  a_lock_clear: assert property (cmd_wr && op == `OP_LOCK_CLEAR && !write_in_progress_flag
    && hw_reset_n |-> ##[1:3] !guard_lock_bit)
    else $error("lock clear did not clear");
  a_prog_busy: assert property (cmd_wr && (op == `OP_NV_PROG || op == `OP_NV_ERASE)
    && !write_in_progress_flag && guard_lock_bit && hw_reset_n |=> write_in_progress_flag [*8])
    else $error("guard program busy too short");
  a_busy_bound: assert property (busy_cnt_q <= BUSY_MAX)
    else $error("busy never ends");
  a_vclr_prot: assert property (cmd_wr && op == `OP_V_CLEAR && !write_in_progress_flag
    && hw_reset_n |-> ##[1:3] sector_prot[sec_q])
    else $error("volatile clear left sector open");

  c_erase: cover property (cmd_wr && op == `OP_NV_ERASE);
  c_lock_set: cover property ($rose(guard_lock_bit));
  c_slverr: cover property (pslverr);
endmodule

// ===== tb/tb_top.sv
/*
  self-checking bench of sector_guard.
  assumes apb_host as master and short busy counts.
*/
`timescale 1ns/1ps
`include "sector_guard_consts.vh"
module tb_top;
  logic        pclk, presetn, wp_n, hw_reset_n, err;
  logic        psel, penable, pwrite, pready, pslverr;
  logic        write_in_progress_flag, guard_lock_bit;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, st;
  logic [63:0] sector_prot;
  int          fails, checks_done, cyc;
  typedef struct { logic [7:0] a; logic [31:0] d; logic [63:0] p; } row_t;
  row_t        rows [10];

  sector_guard #(.SAW(6), .PAGE_CYC(32'd16), .ERASE_CYC(32'd20), .UNLOCK_CYC(32'd12)) u_sector_guard (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wp_n(wp_n), .hw_reset_n(hw_reset_n), .write_in_progress_flag(write_in_progress_flag),
    .guard_lock_bit(guard_lock_bit), .sector_prot(sector_prot));
  apb_host u_apb_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_apb_host.xfer(1'b1, a, d, st, err);
  endtask
  task automatic rd(input logic [7:0] a);
    u_apb_host.xfer(1'b0, a, 32'h0, st, err);
  endtask
  task automatic cmd(input logic [3:0] op, input logic [5:0] sec);
    wr(`OFS_CMD, {10'h0, sec, 12'h0, op});
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    @(negedge pclk);
    while (write_in_progress_flag !== 1'b0 && n < 200) begin
      @(negedge pclk);
      n++;
    end
    chk(64'(write_in_progress_flag), 64'h0);
    repeat (2) @(posedge pclk);
  endtask
  task automatic hw_pulse;
    @(posedge pclk) hw_reset_n <= 1'b0;
    repeat (6) @(posedge pclk);
    hw_reset_n <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  task automatic give_verdict;
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict;
    end
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    wp_n = 1'b1;
    hw_reset_n = 1'b1;
    fails = 0;
    checks_done = 0;
    cyc = 0;
    rows = '{'{`OFS_CMD, 32'h0003_0003, 64'h8}, '{`OFS_CMD, 32'h003f_0003, 64'h8000_0000_0000_0008},
             '{`OFS_CMD, 32'h0003_0004, 64'h8000_0000_0000_0000}, '{`OFS_CMD, 32'h003f_0004, 64'h0},
             '{`OFS_SR, 32'h04, 64'h8000_0000_0000_0000}, '{`OFS_SR, 32'h2c, 64'hf},
             '{`OFS_SR, 32'h1c, ~64'h0}, '{`OFS_SR, 32'h0, 64'h0},
             '{`OFS_CMD, 32'h0005_0003, 64'h20}, '{`OFS_CMD, 32'h9, 64'h0}};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(64'(guard_lock_bit), 64'h1);
    chk(sector_prot, 64'h0);
    rd(`OFS_STATUS);
    chk(64'(st[4:3]), 64'h3);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      repeat (3) @(posedge pclk);
      chk(sector_prot, rows[i].p);
    end
    wr(`OFS_SR, 32'h80);
    @(posedge pclk) wp_n <= 1'b0;
    repeat (3) @(posedge pclk);
    wr(`OFS_SR, 32'h1c);
    rd(`OFS_SR);
    chk(64'(st & 32'hbc), 64'h80);
    @(posedge pclk) wp_n <= 1'b1;
    repeat (3) @(posedge pclk);
    wr(`OFS_SR, 32'h0);
    rd(`OFS_SR);
    chk(64'(st & 32'hbc), 64'h0);
    u_apb_host.xfer(1'b0, 8'h40, 32'h0, st, err);
    chk(64'({err, st}), 64'h1_0000_0000);
    // guard program, read, check, erase
    cmd(`OP_NV_PROG, 6'd10);
    @(negedge pclk);
    chk(64'(write_in_progress_flag), 64'h1);
    wait_idle;
    chk(64'(sector_prot[11:10]), 64'h1);
    cmd(`OP_READ_GUARD, 6'd10);
    rd(`OFS_STATUS);
    chk(64'({st[7], st[6]}), 64'h2);
    cmd(`OP_ARRAY_CHECK, 6'd10);
    rd(`OFS_STATUS);
    chk(64'({st[5], st[1]}), 64'h3);
    cmd(`OP_ERR_CLEAR, 6'd0);
    cmd(`OP_ARRAY_CHECK, 6'd11);
    rd(`OFS_STATUS);
    chk(64'({st[5], st[1]}), 64'h0);
    cmd(`OP_NV_ERASE, 6'd0);
    wait_idle;
    chk(sector_prot, 64'h0);
    // lock cleared after guard bits set
    cmd(`OP_LOCK_CLEAR, 6'd0);
    cmd(`OP_NV_PROG, 6'd20);
    wait_idle;
    rd(`OFS_STATUS);
    chk(64'({st[2], st[1]}), 64'h1);
    chk(sector_prot, 64'h0);
    cmd(`OP_ERR_CLEAR, 6'd0);
    cmd(`OP_PWD_UNLOCK, 6'd0);
    cmd(`OP_SOFT_RESET, 6'd0);
    repeat (3) @(posedge pclk);
    chk(64'(guard_lock_bit), 64'h0);
    cmd(`OP_V_CLEAR, 6'd30);
    hw_pulse;
    chk(64'({guard_lock_bit, sector_prot[30]}), 64'h2);
    wr(`OFS_MODE, 32'h0);
    wait_idle;
    rd(`OFS_STATUS);
    chk(64'({st[4:3], st[1]}), 64'h7);
    cmd(`OP_ERR_CLEAR, 6'd0);
    wr(`OFS_PWD_LO, 32'h89ab_cdef);
    wr(`OFS_PWD_HI, 32'h0123_4567);
    cmd(`OP_PWD_PROG, 6'd0);
    wait_idle;
    wr(`OFS_MODE, 32'h2);
    @(negedge pclk);
    chk(64'(write_in_progress_flag), 64'h1);
    wait_idle;
    wr(`OFS_MODE, 32'h4);
    wait_idle;
    rd(`OFS_STATUS);
    chk(64'({st[4:3], st[1]}), 64'h3);
    cmd(`OP_ERR_CLEAR, 6'd0);
    hw_pulse;
    chk(64'(guard_lock_bit), 64'h0);
    wr(`OFS_PWD_LO, 32'h89ab_cdee);
    cmd(`OP_PWD_UNLOCK, 6'd0);
    @(negedge pclk);
    chk(64'(write_in_progress_flag), 64'h1);
    wait_idle;
    rd(`OFS_STATUS);
    chk(64'({st[2], st[1]}), 64'h1);
    cmd(`OP_ERR_CLEAR, 6'd0);
    wr(`OFS_PWD_LO, 32'h89ab_cdef);
    cmd(`OP_PWD_UNLOCK, 6'd0);
    @(negedge pclk);
    chk(64'({guard_lock_bit, write_in_progress_flag}), 64'h2);
    cmd(`OP_LOCK_CLEAR, 6'd0);
    repeat (3) @(posedge pclk);
    chk(64'(guard_lock_bit), 64'h0);
    // second power-on, then fix persistent mode
    @(posedge pclk) presetn <= 1'b0;
    @(posedge pclk) presetn <= 1'b1;
    @(negedge pclk);
    chk(64'(guard_lock_bit), 64'h1);
    wr(`OFS_MODE, 32'h4);
    wait_idle;
    rd(`OFS_STATUS);
    chk(64'({st[4:3], st[1]}), 64'h4);
    cmd(`OP_LOCK_CLEAR, 6'd0);
    cmd(`OP_PWD_UNLOCK, 6'd0);
    repeat (3) @(posedge pclk);
    chk(64'(guard_lock_bit), 64'h0);
    give_verdict;
  end
endmodule

bind sector_guard sector_guard_asserts #(
  .SAW(SAW), .PAGE_CYC(PAGE_CYC), .ERASE_CYC(ERASE_CYC), .UNLOCK_CYC(UNLOCK_CYC)
) u_sector_guard_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .hw_reset_n(hw_reset_n), .write_in_progress_flag(write_in_progress_flag),
  .guard_lock_bit(guard_lock_bit), .sector_prot(sector_prot)
);
